// >>> hdl/nvm_access_regs.svh
`ifndef NVM_ACCESS_REGS_SVH
`define NVM_ACCESS_REGS_SVH
// Register byte offsets on the bus.
`define OFS_CONTROL 5'h00
`define OFS_UNLOCK 5'h04
`define OFS_ADDRESS 5'h08
`define OFS_DATA 5'h0C
`define OFS_IRQ_STATUS 5'h10
`define OFS_IRQ_MASK 5'h14
// Control register field positions.
`define CTL_SPACE_BIT 7
`define CTL_ERR_BIT 3
`define CTL_ALLOW_BIT 2
`define CTL_PROG_BIT 1
`define CTL_FETCH_BIT 0
`define CTL_RESET 8'h00
// Unlock key bytes.
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
// Write cycle time in microseconds and clock in MHz.
`define WRITE_TIME_US 32'h0000_0028
`define CLK_MHZ 32'h0000_007D
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`endif

// >>> hdl/nvm_access_pkg.sv
package nvm_access_pkg;
	typedef enum logic [1:0] {
		UNLOCK_IDLE,
		UNLOCK_HALF,
		UNLOCK_OPEN
	} unlock_e;
	typedef enum logic {
		CELL_IDLE,
		CELL_WRITING
	} cell_e;
endpackage : nvm_access_pkg

// >>> hdl/data_eeprom_access_ctrl.sv
`timescale 1ns/1ps
`include "nvm_access_regs.svh"

// Overview of operation
// - Control bits 7,3,2,1,0; bits 6-4 zero
// - Fetch loads data next cycle, self clears
// - Data register holds until read or write
// - Write needs 55h, AAh, then program trigger
// - Program trigger refused while write-allow clear
// - Hardware never clears write-allow
// - Clearing write-allow never aborts active write
// - Completion clears trigger, sets done flag
// - Reset during write sets write-error flag, except a watchdog while sleeping
module data_eeprom_access_ctrl
	import nvm_access_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DEPTH = 256,
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Device reset sources, already on this clock.
	input wire logic mclr_rst,
	input wire logic wdt_rst,
	input wire logic sleeping,
	input wire logic bor_rst,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Interrupt.
	output logic irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic req;
	logic wr;
	logic ack_reg, ack_next;
	logic err_reg, err_next;
	logic [31:0] rdat_reg, rdat_next;
	logic hit_ctl, hit_unl, hit_adr, hit_dat, hit_sts, hit_msk, mapped;
	logic lane0;

	assign req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
	assign wr = req & wb_we_i & lane0;
	assign lane0 = wb_sel_i[0];
	assign hit_ctl = (wb_adr_i == `OFS_CONTROL);
	assign hit_unl = (wb_adr_i == `OFS_UNLOCK);
	assign hit_adr = (wb_adr_i == `OFS_ADDRESS);
	assign hit_dat = (wb_adr_i == `OFS_DATA);
	assign hit_sts = (wb_adr_i == `OFS_IRQ_STATUS);
	assign hit_msk = (wb_adr_i == `OFS_IRQ_MASK);
	assign mapped = hit_ctl | hit_unl | hit_adr | hit_dat | hit_sts | hit_msk;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] mem_reg [DEPTH];
	logic [7:0] mem_next [DEPTH];
	logic [ADDR_W-1:0] address_reg, address_next;
	logic [7:0] data_reg, data_next;
	logic space_reg, space_next;
	logic err_flag_reg, err_flag_next;
	logic allow_reg, allow_next;
	logic prog_reg, prog_next;
	logic fetch_reg, fetch_next;
	logic [1:0] status_reg, status_next;
	logic [1:0] mask_reg, mask_next;
	unlock_e unlock_reg, unlock_next;
	cell_e cell_reg, cell_next;
	logic [31:0] count_reg, count_next;
	logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
	logic [7:0] wr_data_reg, wr_data_next;
	logic cut_short;
	logic start_write;
	logic done_write;

	// A reset source that lands mid-write spoils the cell; a watchdog
	// wake from sleep is not counted.
	assign cut_short = (cell_reg == CELL_WRITING) &
		(mclr_rst | (wdt_rst & ~sleeping) | bor_rst);

	function automatic logic [7:0] control_view(input logic sp, input logic er,
		input logic al, input logic pr, input logic fe);
		control_view = 8'h00;
		control_view[`CTL_SPACE_BIT] = sp;
		control_view[`CTL_ERR_BIT] = er;
		control_view[`CTL_ALLOW_BIT] = al;
		control_view[`CTL_PROG_BIT] = pr;
		control_view[`CTL_FETCH_BIT] = fe;
	endfunction : control_view

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		mem_next = mem_reg;
		address_next = address_reg;
		data_next = data_reg;
		space_next = space_reg;
		err_flag_next = err_flag_reg;
		allow_next = allow_reg;
		prog_next = prog_reg;
		fetch_next = fetch_reg;
		status_next = status_reg;
		mask_next = mask_reg;
		unlock_next = unlock_reg;
		cell_next = cell_reg;
		count_next = count_reg;
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		start_write = 1'b0;
		done_write = 1'b0;
		ack_next = req & mapped;
		err_next = req & ~mapped;
		rdat_next = 32'h0000_0000;

		if (req & ~wb_we_i) begin
			case (1'b1)
				hit_ctl: rdat_next[7:0] = control_view(space_reg, err_flag_reg,
					allow_reg, prog_reg, fetch_reg);
				hit_adr: rdat_next[ADDR_W-1:0] = address_reg;
				hit_dat: rdat_next[7:0] = data_reg;
				hit_sts: rdat_next[1:0] = status_reg;
				hit_msk: rdat_next[1:0] = mask_reg;
				default: rdat_next = 32'h0000_0000;
			endcase
		end

		// Fetch completes in the cycle after it was set.
		if (fetch_reg) begin
			data_next = mem_reg[address_reg];
			fetch_next = 1'b0;
		end

		if (wr & hit_adr)
			address_next = wb_dat_i[ADDR_W-1:0];
		if (wr & hit_dat)
			data_next = wb_dat_i[7:0];
		if (wr & hit_msk)
			mask_next = wb_dat_i[1:0];

		// Any bus write on byte lane 0 other than the next key byte closes the lock.
		if (wr) begin
			case (unlock_reg)
				UNLOCK_IDLE: unlock_next = (hit_unl && wb_dat_i[7:0] == `UNLOCK_KEY1) ?
					UNLOCK_HALF : UNLOCK_IDLE;
				UNLOCK_HALF: unlock_next = (hit_unl && wb_dat_i[7:0] == `UNLOCK_KEY2) ?
					UNLOCK_OPEN : UNLOCK_IDLE;
				UNLOCK_OPEN: unlock_next = (hit_unl && wb_dat_i[7:0] == `UNLOCK_KEY1) ?
					UNLOCK_HALF : UNLOCK_IDLE;
				default: unlock_next = UNLOCK_IDLE;
			endcase
		end

		if (wr & hit_ctl) begin
			space_next = wb_dat_i[`CTL_SPACE_BIT];
			allow_next = wb_dat_i[`CTL_ALLOW_BIT];
			err_flag_next = wb_dat_i[`CTL_ERR_BIT];
			if (wb_dat_i[`CTL_FETCH_BIT] & ~wb_dat_i[`CTL_SPACE_BIT])
				fetch_next = 1'b1;
			// Triggers can only be set by software, never cleared.
			if (wb_dat_i[`CTL_PROG_BIT] & wb_dat_i[`CTL_ALLOW_BIT] & allow_reg &
				~wb_dat_i[`CTL_SPACE_BIT] & (unlock_reg == UNLOCK_OPEN) &
				(cell_reg == CELL_IDLE)) begin
				start_write = 1'b1;
			end
		end

		case (cell_reg)
			CELL_IDLE: begin
				if (start_write) begin
					cell_next = CELL_WRITING;
					prog_next = 1'b1;
					count_next = 32'(WRITE_CYCLES - 1);
					wr_addr_next = address_reg;
					wr_data_next = data_reg;
				end
			end
			CELL_WRITING: begin
				// The allow bit is not consulted here on purpose.
				if (count_reg == 32'h0000_0000) begin
					done_write = 1'b1;
					cell_next = CELL_IDLE;
					prog_next = 1'b0;
					err_flag_next = 1'b0;
					mem_next[wr_addr_reg] = wr_data_reg;
				end else begin
					count_next = count_reg - 32'h0000_0001;
				end
			end
			default: cell_next = CELL_IDLE;
		endcase

		if (cut_short) begin
			cell_next = CELL_IDLE;
			prog_next = 1'b0;
			err_flag_next = 1'b1;
		end

		// Status bit 0 is write done, bit 1 is write cut short; set wins.
		if (wr & hit_sts)
			status_next = status_reg & ~wb_dat_i[1:0];
		if (done_write)
			status_next[0] = 1'b1;
		if (cut_short)
			status_next[1] = 1'b1;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= 8'h00;
			address_reg <= '0;
			data_reg <= 8'h00;
			space_reg <= 1'b0;
			err_flag_reg <= 1'b0;
			allow_reg <= 1'b0;
			prog_reg <= 1'b0;
			fetch_reg <= 1'b0;
			status_reg <= 2'h0;
			mask_reg <= 2'h0;
			unlock_reg <= UNLOCK_IDLE;
			cell_reg <= CELL_IDLE;
			count_reg <= 32'h0000_0000;
			wr_addr_reg <= '0;
			wr_data_reg <= 8'h00;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			mem_reg <= mem_next;
			address_reg <= address_next;
			data_reg <= data_next;
			space_reg <= space_next;
			err_flag_reg <= err_flag_next;
			allow_reg <= allow_next;
			prog_reg <= prog_next;
			fetch_reg <= fetch_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			unlock_reg <= unlock_next;
			cell_reg <= cell_next;
			count_reg <= count_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdat_reg <= rdat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdat_reg;
	assign irq = |(status_reg & mask_reg);

endmodule : data_eeprom_access_ctrl

// >>> verif/data_eeprom_access_ctrl_assertions.sv
`timescale 1ns/1ps
`include "nvm_access_regs.svh"
module data_eeprom_access_ctrl_checker (
	// Watched ports.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic mclr_rst,
	input wire logic wdt_rst,
	input wire logic bor_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && clk_en |=> wb_ack_o || wb_err_o; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_err_pulse; wb_err_o |=> !wb_err_o; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("err longer than one cycle");
	property p_excl; !(wb_ack_o && wb_err_o); endproperty
	a_excl: assert property (p_excl) else $error("ack and err together");
	property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_ctl_rsv; wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `OFS_CONTROL |-> wb_dat_o[6:4] == 3'h0 && !wb_dat_o[0]; endproperty
	a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved or fetch bit set");
	property p_unlock_rd; wb_ack_o && $past(wb_adr_i) == `OFS_UNLOCK |-> wb_dat_o == 32'h0; endproperty
	a_unlock_rd: assert property (p_unlock_rd) else $error("unlock port read not zero");
	property p_wr_zero; wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
	property p_err_map; wb_err_o |-> !($past(wb_adr_i) inside {`OFS_CONTROL, `OFS_UNLOCK, `OFS_ADDRESS, `OFS_DATA, `OFS_IRQ_STATUS, `OFS_IRQ_MASK}); endproperty
	a_err_map: assert property (p_err_map) else $error("err on mapped address");
	c_err: cover property (wb_err_o);
	c_irq: cover property (irq);
	c_src: cover property (mclr_rst || wdt_rst || bor_rst);
endmodule : data_eeprom_access_ctrl_checker
bind data_eeprom_access_ctrl data_eeprom_access_ctrl_checker chk_u (.*);

// >>> verif/data_eeprom_access_ctrl_bench.sv
`timescale 1ns/1ps
`include "nvm_access_regs.svh"
module data_eeprom_access_ctrl_bench;
	logic clk = 0;
	logic arst_n = 0;
	logic [2:0] src = 0;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, e, wb_ack_o, wb_err_o, irq;
	logic en = 1, sleep = 0;
	logic [3:0] wb_sel_i = 0;
	logic [4:0] wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q, s = 32'hEF8AB4E5;
	logic [7:0] a, d;
	logic [4:0] ofs[6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
	logic [7:0] tbl[3][4] = '{'{8'h04, 8'hAA, 8'h55, 8'h06}, '{8'h04, 8'h55, 8'hAA, 8'h02},
		'{8'h84, 8'h55, 8'hAA, 8'h86}};
	int n_errors = 0, compares = 0, mem_m[256];
	always #4 clk = ~clk;
	data_eeprom_access_ctrl #(.WRITE_CYCLES(20)) dut_u (.clk(clk), .arst_n(arst_n),
		.clk_en(en), .mclr_rst(src[0]), .wdt_rst(src[1]), .sleeping(sleep), .bor_rst(src[2]),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .irq(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// -------------------------------------------------------------
	// Bus cycle: the answer is read at the edge where ack is sampled.
	// -------------------------------------------------------------
	task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] dt);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, dt};
		// Only the watchdog ends a wait for an answer that never comes.
		do begin
			@(posedge clk);
		end while (!wb_ack_o && !wb_err_o);
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rdmem(input logic [7:0] ad);
		bus(1, `OFS_ADDRESS, ad);
		bus(1, `OFS_CONTROL, 8'h01);
		bus(0, `OFS_DATA, 0);
		chk("cell_data", q, mem_m[ad]);
	endtask : rdmem
	task automatic prog(input logic [7:0] pre, k1, k2, go);
		bus(1, `OFS_ADDRESS, a);
		bus(1, `OFS_DATA, d);
		bus(1, `OFS_CONTROL, pre);
		bus(1, `OFS_UNLOCK, k1);
		bus(1, `OFS_UNLOCK, k2);
		bus(1, `OFS_CONTROL, go);
	endtask : prog
	task automatic complete_run;
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		foreach (ofs[i]) begin
			bus(0, ofs[i], 0);
			chk("reset value", q, 0);
		end
		bus(0, 5'h18, 0);
		chk("unmapped err", e, 1);
		for (int k = 0; k < 2; k++) begin
			s = lfsr(s);
			a = s[7:0];
			d = s[15:8];
			bus(1, `OFS_IRQ_MASK, 8'h01);
			prog(8'h04, 8'h55, 8'hAA, 8'h06);
			// A frozen clock enable must hold the write longer than its own length.
			if (k) begin
				en <= 1'b0;
				repeat (30) @(posedge clk);
				en <= 1'b1;
			end
			// Clearing write-allow and program mid-write must leave the cycle running.
			if (k == 0) bus(1, `OFS_CONTROL, 8'h00);
			bus(0, `OFS_CONTROL, 0);
			chk("control busy", q, k ? 32'h06 : 32'h02);
			repeat (60) if (q[1]) bus(0, `OFS_CONTROL, 0);
			mem_m[a] = d;
			chk("control done", q, k ? 32'h04 : 32'h00);
			chk("irq raised", irq, 1);
			bus(1, `OFS_IRQ_MASK, 8'h00);
			chk("irq masked", irq, 0);
			bus(0, `OFS_IRQ_STATUS, 0);
			chk("status", q, 1);
			bus(1, `OFS_IRQ_STATUS, 8'h01);
			rdmem(a);
		end
		foreach (tbl[i]) begin
			s = lfsr(s);
			a = s[7:0];
			d = 8'(~mem_m[a]);
			prog(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
			bus(0, `OFS_CONTROL, 0);
			chk("control refused", q, tbl[i][3] & 8'hFD);
			rdmem(a);
		end
		// The fourth pass is a watchdog while asleep, which must not spoil the write.
		for (int i = 0; i < 4; i++) begin
			s = lfsr(s);
			a = s[7:0];
			d = 8'(~mem_m[a]);
			prog(8'h04, 8'h55, 8'hAA, 8'h06);
			src <= (i == 3) ? 3'h2 : 3'(1 << i);
			sleep <= (i == 3);
			@(posedge clk);
			src <= 3'h0;
			sleep <= 1'b0;
			bus(0, `OFS_CONTROL, 0);
			repeat (60) if (q[1]) bus(0, `OFS_CONTROL, 0);
			if (i == 3) mem_m[a] = d;
			chk("cut short control", q & 32'h0A, (i == 3) ? 32'h00 : 32'h08);
			bus(0, `OFS_IRQ_STATUS, 0);
			chk("cut short status", q & 32'h02, (i == 3) ? 32'h00 : 32'h02);
			bus(1, `OFS_IRQ_STATUS, 8'h03);
			rdmem(a);
		end
		complete_run();
	end
endmodule : data_eeprom_access_ctrl_bench
